// file: hphs_pkg.sv
// Package with offsets, field positions and reset values for the host port status block
package hphs_pkg;
	// Host port offsets (4-bit host address)
	localparam logic [3:0] HOST_ADDR_BUF     = 4'h0;
	localparam logic [3:0] HOST_ADDR_DLM     = 4'h1;
	localparam logic [3:0] HOST_ADDR_IIR     = 4'h2;
	localparam logic [3:0] HOST_ADDR_LINE    = 4'h5;
	localparam logic [3:0] HOST_ADDR_MODEM   = 4'h6;
	localparam logic [3:0] HOST_ADDR_SCRATCH = 4'h7;
	localparam logic [3:0] HOST_ADDR_HSHAKE  = 4'hF;
	// CPU side offsets
	localparam logic [7:0] CPU_ADDR_DLL      = 8'h20;
	localparam logic [7:0] CPU_ADDR_DLM      = 8'h21;
	localparam logic [7:0] CPU_ADDR_LINE     = 8'h25;
	localparam logic [7:0] CPU_ADDR_MODEM    = 8'h26;
	localparam logic [7:0] CPU_ADDR_SCRATCH  = 8'h27;
	localparam logic [7:0] CPU_ADDR_HSHAKE   = 8'h2F;
	localparam logic [7:0] CPU_ADDR_HCTRL    = 8'h32;
	// Field positions
	localparam int LSR_DATA_READY   = 0;
	localparam int LSR_TX_HOLDING_EMPTY         = 5;
	localparam int LSR_TX_EMPTY     = 6;
	localparam int HCR_DIV_FLAG     = 4;
	localparam int MCR_AUX_TWO      = 3;
	localparam int MCR_LOOP         = 4;
	localparam int IER_RX_FULL      = 0;
	localparam int IER_TX_EMPTY     = 1;
	localparam int IER_LINE_STAT    = 2;
	localparam int IER_MODEM_STAT   = 3;
	// Masks
	localparam logic [7:0] LSR_SET_MASK   = 8'h7F;
	localparam logic [7:0] LSR_ERR_MASK   = 8'h1E;
	localparam logic [7:0] MSR_DELTA_MASK = 8'h0F;
	localparam logic [7:0] MSR_STATE_MASK = 8'hF0;
	localparam logic [7:0] HHR_HOST_EN    = 8'h03;
	localparam logic [7:0] HHR_CTRL_EN    = 8'h0C;
	localparam logic [7:0] HHR_HOST_FLAG  = 8'h30;
	localparam logic [7:0] HHR_CTRL_FLAG  = 8'hC0;
	// Reset values
	localparam logic [7:0] LSR_RESET = 8'h00;
	localparam logic [7:0] MSR_RESET = 8'h00;
	localparam logic [7:0] HHR_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// file: hphs_strobe_pulse.sv
// One-pulse-per-access detector for a host strobe
`timescale 1ns/10ps
`default_nettype none
module hphs_strobe_pulse (
	input  wire logic clk,       // Device clock
	input  wire logic srst,      // Synchronous reset
	input  wire logic strobe,    // Host strobe level
	output logic      pulse      // One cycle at strobe start
);
	logic prev_q;

	// Remember last level
	always_ff @(posedge clk) begin
		if (srst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= strobe;
		end
	end

	// Rising edge only, so a long strobe acts once
	assign pulse = strobe & ~prev_q;
endmodule
`default_nettype wire

// file: hphs_regs.sv
// Host/CPU dual-port status and handshake registers
`timescale 1ns/10ps
`default_nettype none
module hphs_regs
	import hphs_pkg::*;
(
	input  wire logic       clk,            // Device clock, 25 MHz
	input  wire logic       srst,           // Synchronous reset
	input  wire logic       hostSelect,     // Host chip select
	input  wire logic [3:0] hostAddr,       // Host address
	input  wire logic       hostRead,       // Host read strobe level
	input  wire logic       hostWrite,      // Host write strobe level
	input  wire logic [7:0] hostDataIn,     // Host data from pins
	output logic      [7:0] hostDataOut,    // Host read data
	output logic            hostDataOe,     // Drive host data pins
	output logic            host_irq_out,   // Host interrupt level
	output logic            hostIrqOe,      // Drive host interrupt pin
	input  wire logic       dlab,           // Divisor latch access bit
	input  wire logic       uartMode,       // UART emulation mode
	input  wire logic [7:0] modem_control_reg, // Modem control bits
	input  wire logic [3:0] host_irq_enable_reg, // Host interrupt enables
	input  wire logic [7:0] cpuAddr,        // CPU address
	input  wire logic       cpuWrite,       // CPU write strobe
	input  wire logic [7:0] cpuWrData,      // CPU write data
	output logic      [7:0] cpuRdData,      // CPU read data
	output logic            cpu_handshake_irq, // CPU handshake interrupt
	output logic            divUpdateFlag   // Host control divisor flag
);
	import hphs_pkg::*;

	logic [7:0] line_status_reg_q;
	logic [7:0] modem_status_reg_q;
	logic [7:0] handshake_reg_q;
	logic [7:0] line_status_reg_d;
	logic [7:0] modem_status_reg_d;
	logic [7:0] handshake_reg_d;
	logic [7:0] divLow_q;
	logic [7:0] divHigh_q;
	logic [7:0] scratch_q;
	logic       divFlag_q;
	logic       threReleased_q;
	logic [7:0] hostRdData_q;
	logic       hostRdEn_q;
	logic [7:0] cpuRdData_q;
	logic       hostRdPulse;
	logic       hostWrPulse;
	logic       hRd;
	logic       hWr;
	logic [7:0] msrView;
	logic       thrWr;
	logic       rbrRd;
	logic       iirRd;
	logic       lsrRd;
	logic       msrRd;
	logic       hhrHostOk;
	logic [7:0] cw0;
	logic       txIrq;
	logic       irqCause;

	// Strobe edge detectors, one event per access
	hphs_strobe_pulse uRdPulse (
		.clk    (clk),
		.srst   (srst),
		.strobe (hostRead & hostSelect),
		.pulse  (hostRdPulse)
	);
	hphs_strobe_pulse uWrPulse (
		.clk    (clk),
		.srst   (srst),
		.strobe (hostWrite & hostSelect),
		.pulse  (hostWrPulse)
	);

	// Host access decode
	assign hRd       = hostRdPulse;
	assign hWr       = hostWrPulse;
	assign thrWr     = hWr && hostAddr == HOST_ADDR_BUF && !dlab;
	assign rbrRd     = hRd && hostAddr == HOST_ADDR_BUF && !dlab;
	assign iirRd     = hRd && hostAddr == HOST_ADDR_IIR;
	assign lsrRd     = hRd && hostAddr == HOST_ADDR_LINE;
	assign msrRd     = hRd && hostAddr == HOST_ADDR_MODEM;
	assign hhrHostOk = !uartMode;
	assign cw0       = ~cpuWrData;

	// Modem state as seen by readers, loopback remaps
	always_comb begin
		msrView = modem_status_reg_q;
		if (modem_control_reg[MCR_LOOP]) begin
			msrView[4] = modem_control_reg[1];
			msrView[5] = modem_control_reg[0];
			msrView[6] = modem_control_reg[2];
			msrView[7] = modem_control_reg[3];
		end
	end

	// Line status next value: CPU zero-writes set, host reads and THR writes clear, host LSR write loads, set wins
	always_comb begin
		line_status_reg_d = line_status_reg_q;
		if (hWr && hostAddr == HOST_ADDR_LINE) begin
			line_status_reg_d = hostDataIn;
		end
		if (rbrRd) begin
			line_status_reg_d[LSR_DATA_READY] = 1'b0;
		end
		if (lsrRd) begin
			line_status_reg_d = line_status_reg_d & ~LSR_ERR_MASK;
		end
		if (thrWr) begin
			line_status_reg_d[LSR_TX_HOLDING_EMPTY]     = 1'b0;
			line_status_reg_d[LSR_TX_EMPTY] = 1'b0;
		end
		if (cpuWrite && cpuAddr == CPU_ADDR_LINE) begin
			line_status_reg_d = line_status_reg_d | (cw0 & LSR_SET_MASK);
		end
		line_status_reg_d = line_status_reg_d & LSR_SET_MASK;
	end

	// Line status register
	always_ff @(posedge clk) begin
		if (srst) begin
			line_status_reg_q <= LSR_RESET;
		end else begin
			line_status_reg_q <= line_status_reg_d;
		end
	end

	// Modem status next value: change bits set by CPU zeros, state bits plain
	always_comb begin
		modem_status_reg_d = modem_status_reg_q;
		if (hWr && hostAddr == HOST_ADDR_MODEM) begin
			modem_status_reg_d = hostDataIn;
		end
		if (msrRd) begin
			modem_status_reg_d = modem_status_reg_d & ~MSR_DELTA_MASK;
		end
		if (cpuWrite && cpuAddr == CPU_ADDR_MODEM) begin
			// Ring bit is software's trailing-edge marker
			modem_status_reg_d = ((modem_status_reg_d | (cw0 & MSR_DELTA_MASK)) & MSR_DELTA_MASK)
				| (cpuWrData & MSR_STATE_MASK);
		end
	end

	// Modem status register
	always_ff @(posedge clk) begin
		if (srst) begin
			modem_status_reg_q <= MSR_RESET;
		end else begin
			modem_status_reg_q <= modem_status_reg_d;
		end
	end

	// Divisor and scratch bytes: no reset, contents survive
	always_ff @(posedge clk) begin
		if (cpuWrite && cpuAddr == CPU_ADDR_DLL) begin
			divLow_q <= cpuWrData;
		end else if (hWr && hostAddr == HOST_ADDR_BUF && dlab) begin
			divLow_q <= hostDataIn;
		end
		if (cpuWrite && cpuAddr == CPU_ADDR_DLM) begin
			divHigh_q <= cpuWrData;
		end else if (hWr && hostAddr == HOST_ADDR_DLM && dlab) begin
			divHigh_q <= hostDataIn;
		end
		if (cpuWrite && cpuAddr == CPU_ADDR_SCRATCH) begin
			scratch_q <= cpuWrData;
		end else if (hWr && hostAddr == HOST_ADDR_SCRATCH) begin
			scratch_q <= hostDataIn;
		end
	end

	// Divisor update flag, CPU clears by zero write, set wins
	always_ff @(posedge clk) begin
		if (srst) begin
			divFlag_q <= 1'b0;
		end else if (hWr && dlab && (hostAddr == HOST_ADDR_BUF || hostAddr == HOST_ADDR_DLM)) begin
			divFlag_q <= 1'b1;
		end else if (cpuWrite && cpuAddr == CPU_ADDR_HCTRL && !cpuWrData[HCR_DIV_FLAG]) begin
			divFlag_q <= 1'b0;
		end
	end
	assign divUpdateFlag = divFlag_q;

	// Handshake next value: per-field ownership, sets applied last so they win
	always_comb begin
		handshake_reg_d = handshake_reg_q;
		if (cpuWrite && cpuAddr == CPU_ADDR_HSHAKE) begin
			handshake_reg_d = (handshake_reg_d & ~HHR_CTRL_EN) | (cpuWrData & HHR_CTRL_EN);
			handshake_reg_d = handshake_reg_d & ~(cw0 & HHR_CTRL_FLAG);
		end
		if (hWr && hostAddr == HOST_ADDR_HSHAKE && hhrHostOk) begin
			handshake_reg_d = (handshake_reg_d & ~HHR_HOST_EN) | (hostDataIn & HHR_HOST_EN);
			handshake_reg_d = handshake_reg_d & ~(~hostDataIn & HHR_HOST_FLAG);
			handshake_reg_d = handshake_reg_d | (hostDataIn & HHR_CTRL_FLAG);
		end
		if (cpuWrite && cpuAddr == CPU_ADDR_HSHAKE) begin
			handshake_reg_d = handshake_reg_d | (cw0 & HHR_HOST_FLAG);
		end
	end

	// Handshake register
	always_ff @(posedge clk) begin
		if (srst) begin
			handshake_reg_q <= HHR_RESET;
		end else begin
			handshake_reg_q <= handshake_reg_d;
		end
	end

	// Transmit-empty interrupt release until CPU re-arms TX_HOLDING_EMPTY
	always_ff @(posedge clk) begin
		if (srst) begin
			threReleased_q <= 1'b0;
		end else if (cpuWrite && cpuAddr == CPU_ADDR_LINE && !cpuWrData[LSR_TX_HOLDING_EMPTY]) begin
			threReleased_q <= 1'b0;
		end else if (thrWr || iirRd) begin
			threReleased_q <= 1'b1;
		end
	end

	// Host interrupt sources
	assign txIrq = host_irq_enable_reg[IER_TX_EMPTY] && line_status_reg_q[LSR_TX_HOLDING_EMPTY] && !threReleased_q;
	assign irqCause = (host_irq_enable_reg[IER_RX_FULL] && line_status_reg_q[LSR_DATA_READY])
		|| txIrq
		|| (host_irq_enable_reg[IER_LINE_STAT] && |(line_status_reg_q & LSR_ERR_MASK))
		|| (host_irq_enable_reg[IER_MODEM_STAT] && |(modem_status_reg_q & MSR_DELTA_MASK))
		|| (hhrHostOk && ((handshake_reg_q[0] && handshake_reg_q[4])
			|| (handshake_reg_q[1] && handshake_reg_q[5])));
	assign host_irq_out = irqCause;
	assign hostIrqOe    = modem_control_reg[MCR_AUX_TWO];

	// CPU handshake interrupt
	assign cpu_handshake_irq = (handshake_reg_q[2] && handshake_reg_q[6])
		|| (handshake_reg_q[3] && handshake_reg_q[7]);

	// Host read data captured at strobe start
	always_ff @(posedge clk) begin
		if (srst) begin
			hostRdData_q <= BYTE_ZERO;
			hostRdEn_q   <= 1'b0;
		end else begin
			hostRdEn_q <= hostRead & hostSelect;
			if (hRd) begin
				case (hostAddr)
					HOST_ADDR_BUF:     hostRdData_q <= dlab ? divLow_q : BYTE_ZERO;
					HOST_ADDR_DLM:     hostRdData_q <= dlab ? divHigh_q : BYTE_ZERO;
					HOST_ADDR_LINE:    hostRdData_q <= line_status_reg_q;
					HOST_ADDR_MODEM:   hostRdData_q <= msrView;
					HOST_ADDR_SCRATCH: hostRdData_q <= scratch_q;
					HOST_ADDR_HSHAKE:  hostRdData_q <= hhrHostOk ? handshake_reg_q : BYTE_ZERO;
					default:           hostRdData_q <= BYTE_ZERO;
				endcase
			end
		end
	end
	assign hostDataOut = hostRdData_q;
	assign hostDataOe  = hostRdEn_q & hostRead & hostSelect;

	// CPU read data, one cycle after address
	always_ff @(posedge clk) begin
		if (srst) begin
			cpuRdData_q <= BYTE_ZERO;
		end else begin
			case (cpuAddr)
				CPU_ADDR_DLL:     cpuRdData_q <= divLow_q;
				CPU_ADDR_DLM:     cpuRdData_q <= divHigh_q;
				CPU_ADDR_LINE:    cpuRdData_q <= line_status_reg_q;
				CPU_ADDR_MODEM:   cpuRdData_q <= msrView;
				CPU_ADDR_SCRATCH: cpuRdData_q <= scratch_q;
				CPU_ADDR_HSHAKE:  cpuRdData_q <= handshake_reg_q;
				CPU_ADDR_HCTRL:   cpuRdData_q <= {3'h0, divFlag_q, 4'h0};
				default:          cpuRdData_q <= BYTE_ZERO;
			endcase
		end
	end
	assign cpuRdData = cpuRdData_q;

	// Checks
	chk_lsr_bit7_zero: assert property (@(posedge clk) disable iff (srst) !line_status_reg_q[7])
		else $error("line status bit 7 not zero");
	chk_dr_clear: assert property (@(posedge clk) disable iff (srst)
		rbrRd && !(cpuWrite && cpuAddr == CPU_ADDR_LINE) |=> !line_status_reg_q[0])
		else $error("data ready not cleared");
	chk_err_clear: assert property (@(posedge clk) disable iff (srst)
		lsrRd && !(cpuWrite && cpuAddr == CPU_ADDR_LINE) |=> (line_status_reg_q & LSR_ERR_MASK) == 8'h00)
		else $error("error bits not cleared");
	chk_tx_holding_empty_clear: assert property (@(posedge clk) disable iff (srst)
		thrWr && !(cpuWrite && cpuAddr == CPU_ADDR_LINE) |=> !line_status_reg_q[5] && !line_status_reg_q[6])
		else $error("transmit empty bits not cleared");
	chk_lsr_cpu_set: assert property (@(posedge clk) disable iff (srst)
		cpuWrite && cpuAddr == CPU_ADDR_LINE |=> (line_status_reg_q & ~$past(cpuWrData) & 8'h7F) == (~$past(cpuWrData) & 8'h7F))
		else $error("line status zero write did not set");
	chk_msr_delta_clr: assert property (@(posedge clk) disable iff (srst)
		msrRd && !(cpuWrite && cpuAddr == CPU_ADDR_MODEM) |=> (modem_status_reg_q & 8'h0F) == 8'h00)
		else $error("modem change bits not cleared");
	chk_msr_state_keep: assert property (@(posedge clk) disable iff (srst)
		!hWr && !(cpuWrite && cpuAddr == CPU_ADDR_MODEM) |=> $stable(modem_status_reg_q[7:4]))
		else $error("modem state bits changed alone");
	chk_div_flag: assert property (@(posedge clk) disable iff (srst)
		hWr && dlab && (hostAddr == HOST_ADDR_BUF || hostAddr == HOST_ADDR_DLM) |=> divFlag_q)
		else $error("divisor flag not set");
	chk_irq_drive: assert property (@(posedge clk) disable iff (srst)
		hostIrqOe == modem_control_reg[3])
		else $error("host interrupt drive not gated");
	chk_ctrl_flag_set: assert property (@(posedge clk) disable iff (srst)
		hWr && hostAddr == HOST_ADDR_HSHAKE && !uartMode && hostDataIn[7] |=> handshake_reg_q[7])
		else $error("controller flag not set");
	chk_host_flag_set: assert property (@(posedge clk) disable iff (srst)
		cpuWrite && cpuAddr == CPU_ADDR_HSHAKE && !cpuWrData[5] |=> handshake_reg_q[5])
		else $error("host flag not set");
	chk_tx_release: assert property (@(posedge clk) disable iff (srst)
		iirRd && !(cpuWrite && cpuAddr == CPU_ADDR_LINE) |=> !txIrq)
		else $error("transmit interrupt not released");
endmodule
`default_nettype wire

// file: hphs_host_model.sv
// Host processor model for the host bus of the status block
`timescale 1ns/10ps
`default_nettype none
module hphs_host_model (
	input  wire logic       clk,         // Device clock
	output logic            hostSelect,  // Chip select
	output logic      [3:0] hostAddr,    // Register address
	output logic            hostRead,    // Read strobe
	output logic            hostWrite,   // Write strobe
	output logic      [7:0] hostDataIn,  // Write data toward device
	input  wire logic [7:0] hostDataOut, // Read data from device
	input  wire logic       hostDataOe   // Read drive enable from device
);
	int slowHold = 0;

	// Bus idle at time zero
	initial begin
		hostSelect = 1'b0;
		hostAddr = 4'h0;
		hostRead = 1'b0;
		hostWrite = 1'b0;
		hostDataIn = 8'hA5;
	end

	// Write cycle; status writes are allowed but discouraged
	task automatic hwr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		hostSelect <= 1'b1;
		hostAddr <= a;
		hostWrite <= 1'b1;
		hostDataIn <= d;
		repeat (1 + slowHold) @(posedge clk);
		hostSelect <= 1'b0;
		hostWrite <= 1'b0;
		hostDataIn <= ~d; // Released bus shows no stale value
		@(posedge clk);
	endtask

	// Read cycle; data taken before strobe is released
	task automatic hrd(input logic [3:0] a, output logic [7:0] d, output logic oe);
		@(posedge clk);
		hostSelect <= 1'b1;
		hostAddr <= a;
		hostRead <= 1'b1;
		repeat (2 + slowHold) @(posedge clk);
		d = hostDataOut;
		oe = hostDataOe;
		hostSelect <= 1'b0;
		hostRead <= 1'b0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the host port status and handshake registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import hphs_pkg::*;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       dlab = 1'b0;
	logic       uartMode = 1'b0;
	logic [7:0] modem_control_reg = 8'h08;
	logic [3:0] host_irq_enable_reg = 4'h0;
	logic [7:0] cpuAddr = 8'h00;
	logic       cpuWrite = 1'b0;
	logic [7:0] cpuWrData = 8'h00;
	logic [7:0] cpuRdData, hostDataOut, hostDataIn, rd;
	logic [3:0] hostAddr;
	logic       hostSelect, hostRead, hostWrite, hostDataOe, host_irq_out, hostIrqOe;
	logic       cpu_handshake_irq, divUpdateFlag, oeRd;
	int         fails = 0;
	int         checksDone = 0;
	int         cycles = 0;

	// Clock, 40 ns period
	initial begin
		forever #20 clk = ~clk;
	end

	hphs_regs dut_u (.clk(clk), .srst(srst), .hostSelect(hostSelect), .hostAddr(hostAddr),
		.hostRead(hostRead), .hostWrite(hostWrite), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
		.hostDataOe(hostDataOe), .host_irq_out(host_irq_out), .hostIrqOe(hostIrqOe), .dlab(dlab),
		.uartMode(uartMode), .modem_control_reg(modem_control_reg), .host_irq_enable_reg(host_irq_enable_reg),
		.cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuWrData(cpuWrData), .cpuRdData(cpuRdData),
		.cpu_handshake_irq(cpu_handshake_irq), .divUpdateFlag(divUpdateFlag));

	hphs_host_model host_u (.clk(clk), .hostSelect(hostSelect), .hostAddr(hostAddr), .hostRead(hostRead),
		.hostWrite(hostWrite), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe));

	// Verdict and end of run
	task automatic tally_and_finish();
		if (fails == 0 && checksDone > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Byte compare
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask

	// Single flag compare, sampled at once with no wait
	task automatic chk1(input logic got, input logic exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	// CPU write, one-cycle strobe
	task automatic cwr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cpuAddr <= a;
		cpuWrData <= d;
		cpuWrite <= 1'b1;
		@(posedge clk);
		cpuWrite <= 1'b0;
	endtask

	// CPU read and compare
	task automatic cexp(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		cpuAddr <= a;
		repeat (2) @(posedge clk);
		chk8(cpuRdData, exp);
	endtask

	// Host read and compare
	task automatic hexp(input logic [3:0] a, input logic [7:0] exp);
		host_u.hrd(a, rd, oeRd);
		chk8(rd, exp);
		chk1(oeRd, 1'b1);
		chk1(hostDataOe, 1'b0);
	endtask

	// Two settling cycles before a level check
	task automatic settle();
		repeat (2) @(posedge clk);
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails++;
			$display("mismatch at %0t: timeout", $time);
			tally_and_finish();
		end
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		cexp(CPU_ADDR_LINE, 8'h00);
		cexp(CPU_ADDR_MODEM, 8'h00);
		cexp(CPU_ADDR_HSHAKE, 8'h00);
		chk1(divUpdateFlag, 1'b0);
		// Line status set by zeros, bit 7 stuck low
		cwr(CPU_ADDR_LINE, 8'hFE);
		cexp(CPU_ADDR_LINE, 8'h01);
		cwr(CPU_ADDR_LINE, 8'hFF);
		cexp(CPU_ADDR_LINE, 8'h01);
		cwr(CPU_ADDR_LINE, 8'h00);
		cexp(CPU_ADDR_LINE, 8'h7F);
		host_irq_enable_reg <= 4'h4;
		settle();
		chk1(host_irq_out, 1'b1);
		hexp(HOST_ADDR_LINE, 8'h7F);
		settle();
		chk1(host_irq_out, 1'b0);
		cexp(CPU_ADDR_LINE, 8'h61);
		host_u.hrd(HOST_ADDR_BUF, rd, oeRd);
		cexp(CPU_ADDR_LINE, 8'h60);
		// Transmit-empty interrupt release paths
		host_irq_enable_reg <= 4'h2;
		settle();
		chk1(host_irq_out, 1'b1);
		host_u.hrd(HOST_ADDR_IIR, rd, oeRd);
		settle();
		chk1(host_irq_out, 1'b0);
		cwr(CPU_ADDR_LINE, 8'hDF);
		settle();
		chk1(host_irq_out, 1'b1);
		host_u.hwr(HOST_ADDR_BUF, 8'h11);
		settle();
		chk1(host_irq_out, 1'b0);
		cexp(CPU_ADDR_LINE, 8'h00);
		// Modem status with a slow host
		host_irq_enable_reg <= 4'h0;
		host_u.slowHold = 2;
		cwr(CPU_ADDR_MODEM, 8'hA0);
		cexp(CPU_ADDR_MODEM, 8'hAF);
		host_irq_enable_reg <= 4'h8;
		settle();
		chk1(host_irq_out, 1'b1);
		hexp(HOST_ADDR_MODEM, 8'hAF);
		cexp(CPU_ADDR_MODEM, 8'hA0);
		chk1(host_irq_out, 1'b0);
		cwr(CPU_ADDR_MODEM, 8'hF5);
		cexp(CPU_ADDR_MODEM, 8'hFA);
		host_u.hwr(HOST_ADDR_MODEM, 8'h50);
		cexp(CPU_ADDR_MODEM, 8'h50);
		cwr(CPU_ADDR_MODEM, 8'h5B);
		cexp(CPU_ADDR_MODEM, 8'h54);
		hexp(HOST_ADDR_MODEM, 8'h54);
		host_irq_enable_reg <= 4'h0;
		modem_control_reg <= 8'h1A;
		hexp(HOST_ADDR_MODEM, 8'h90);
		chk1(hostIrqOe, 1'b1);
		modem_control_reg <= 8'h15;
		hexp(HOST_ADDR_MODEM, 8'h60);
		chk1(hostIrqOe, 1'b0);
		modem_control_reg <= 8'h08;
		host_u.slowHold = 0;
		// Divisor bytes raise the update flag, scratch does not
		dlab <= 1'b1;
		host_u.hwr(HOST_ADDR_BUF, 8'h5A);
		settle();
		chk1(divUpdateFlag, 1'b1);
		cwr(CPU_ADDR_HCTRL, 8'h00);
		settle();
		chk1(divUpdateFlag, 1'b0);
		host_u.hwr(HOST_ADDR_DLM, 8'hC3);
		settle();
		chk1(divUpdateFlag, 1'b1);
		cwr(CPU_ADDR_HCTRL, 8'h00);
		host_u.hwr(HOST_ADDR_SCRATCH, 8'h3C);
		settle();
		chk1(divUpdateFlag, 1'b0);
		cexp(CPU_ADDR_DLL, 8'h5A);
		cexp(CPU_ADDR_DLM, 8'hC3);
		cexp(CPU_ADDR_SCRATCH, 8'h3C);
		cwr(CPU_ADDR_SCRATCH, 8'h96);
		hexp(HOST_ADDR_SCRATCH, 8'h96);
		hexp(HOST_ADDR_BUF, 8'h5A);
		dlab <= 1'b0;
		// Handshake enables and attention flags
		cwr(CPU_ADDR_HSHAKE, 8'h0F);
		cexp(CPU_ADDR_HSHAKE, 8'h3C);
		chk1(cpu_handshake_irq, 1'b0);
		host_u.hwr(HOST_ADDR_HSHAKE, 8'hF3);
		cexp(CPU_ADDR_HSHAKE, 8'hFF);
		chk1(cpu_handshake_irq, 1'b1);
		chk1(host_irq_out, 1'b1);
		host_u.hwr(HOST_ADDR_HSHAKE, 8'h2C);
		hexp(HOST_ADDR_HSHAKE, 8'hEC);
		chk1(host_irq_out, 1'b0);
		cwr(CPU_ADDR_HSHAKE, 8'h7F);
		cexp(CPU_ADDR_HSHAKE, 8'h6C);
		chk1(cpu_handshake_irq, 1'b1);
		cwr(CPU_ADDR_HSHAKE, 8'h33);
		cexp(CPU_ADDR_HSHAKE, 8'h20);
		chk1(cpu_handshake_irq, 1'b0);
		uartMode <= 1'b1;
		hexp(HOST_ADDR_HSHAKE, 8'h00);
		host_u.hwr(HOST_ADDR_HSHAKE, 8'hC0);
		cexp(CPU_ADDR_HSHAKE, 8'h20);
		uartMode <= 1'b0;
		// Second reset keeps divisor and scratch
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		cexp(CPU_ADDR_HSHAKE, 8'h00);
		cexp(CPU_ADDR_LINE, 8'h00);
		cexp(CPU_ADDR_DLL, 8'h5A);
		cexp(CPU_ADDR_SCRATCH, 8'h96);
		tally_and_finish();
	end
endmodule
`default_nettype wire
